// ===== src/prefetch_bus_sequencer_overlap.sv
`include "prefetch_map.svh"

module prefetch_bus_sequencer_overlap (
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   reset,
	// Instruction prefetch
	input  wire logic                   fetchReq,
	input  wire logic [31:0]            fetchAddr,
	output logic                        fetchReady,
	output logic                        fetchValid,
	output logic [15:0]                 fetchWord,
	// Instruction cache lookup and fill
	input  wire logic                   cacheHit,
	input  wire logic [15:0]            cacheWord,
	output logic                        cacheFill,
	output logic [31:0]                 cacheFillAddr,
	output logic [31:0]                 cacheFillData,
	// Operand access
	input  wire prefetch_pkg::op_req_s  opIn,
	output logic                        opReady,
	output logic                        opDone,
	output logic [31:0]                 opRData,
	// Serialising no-operation instruction
	input  wire logic                   nopReq,
	output logic                        nopDone,
	output logic                        writesPending,
	// External memory
	input  wire logic [1:0]             portWidth,
	output prefetch_pkg::mem_req_s      memOut,
	input  wire logic                   memAck,
	input  wire logic [31:0]            memRData
);

	prefetch_pkg::bus_state_e state, next_state;
	prefetch_pkg::job_s       active, next_active;
	prefetch_pkg::job_s       slot, next_slot;
	prefetch_pkg::job_s       newJob;
	logic [31:0]              acc, next_acc;
	logic [2:0]               portBytes;
	logic [1:0]               offs;
	logic [2:0]               room;
	logic [2:0]               chunk;
	logic                     running;
	logic                     lastChunk;
	logic [31:0]              readValue;
	logic                     lineHit;
	logic [15:0]              lineWord;
	logic                     fetchMiss;
	logic                     fetchTake;
	logic                     opAccept;
	logic                     fetchBusy, next_fetchBusy;
	logic                     fetchOdd, next_fetchOdd;
	logic                     lineValid, next_lineValid;
	logic [31:0]              lineAddr, next_lineAddr;
	logic [31:0]              lineData, next_lineData;
	logic                     next_fetchValid;
	logic [15:0]              next_fetchWord;
	logic                     next_cacheFill;
	logic [31:0]              next_cacheFillAddr;
	logic [31:0]              next_cacheFillData;
	logic                     readBusy, next_readBusy;
	logic                     next_opDone;
	logic [31:0]              next_opRData;

	// Prefetch lookup
	assign lineHit   = lineValid && (lineAddr == (fetchAddr & `LONG_MASK));
	assign lineWord  = fetchAddr[1] ? lineData[15:0] : lineData[31:16];
	assign fetchMiss = !cacheHit && !lineHit;
	assign opReady   = !slot.valid && !readBusy;
	assign opAccept  = opIn.request && opReady;
	assign fetchReady = !fetchBusy && (!fetchMiss || (!slot.valid && !opIn.request));
	assign fetchTake = fetchReq && fetchReady;

	// Job handed to the bus controller; operands take priority
	always_comb begin
		newJob = '0;
		if (opAccept) begin
			newJob.valid = 1'b1;
			newJob.write = opIn.write;
			newJob.addr  = opIn.addr;
			newJob.bytes = opIn.isLong ? `BYTES_LONG : `BYTES_WORD;
			newJob.data  = opIn.isLong ? opIn.wdata : {opIn.wdata[15:0], 16'h0000};
		end else if (fetchTake && fetchMiss) begin
			newJob.valid = 1'b1;
			newJob.fetch = 1'b1;
			newJob.addr  = fetchAddr & `LONG_MASK;
			newJob.bytes = `BYTES_LONG;
		end
	end

	// Bytes per bus cycle from port width and alignment
	always_comb begin
		case (portWidth)
			`PORT_8:  portBytes = `BYTES_BYTE;
			`PORT_16: portBytes = `BYTES_WORD;
			default:  portBytes = `BYTES_LONG;
		endcase
	end
	assign offs  = active.addr[1:0] & 2'(portBytes - `BYTES_BYTE);
	assign room  = portBytes - {1'b0, offs};
	assign chunk = (room < active.bytes) ? room : active.bytes;
	assign running   = (state == prefetch_pkg::BUS_RUN);
	assign lastChunk = running && memAck && (chunk == active.bytes);
	assign readValue = (acc << {chunk, 3'b000})
		| (memRData & ~(32'hFFFF_FFFF << {chunk, 3'b000}));

	// One memory cycle per chunk
	always_comb begin
		memOut         = '0;
		memOut.request = running;
		memOut.write   = active.write;
		memOut.addr    = active.addr;
		memOut.size    = chunk;
		memOut.wdata   = active.data >> {3'(`BYTES_LONG - chunk), 3'b000};
	end

	// Bus controller and one-entry queue
	always_comb begin
		next_state  = state;
		next_active = active;
		next_slot   = slot;
		next_acc    = acc;
		if (running && memAck) begin
			next_acc          = readValue;
			next_active.addr  = active.addr + 32'(chunk);
			next_active.bytes = active.bytes - chunk;
			next_active.data  = active.data << {chunk, 3'b000};
		end
		if (lastChunk || !running) begin
			next_acc = '0;
			if (slot.valid) begin
				next_active = slot;
				next_slot   = '0;
				next_state  = prefetch_pkg::BUS_RUN;
			end else if (newJob.valid) begin
				next_active = newJob;
				next_state  = prefetch_pkg::BUS_RUN;
			end else begin
				next_active = '0;
				next_state  = prefetch_pkg::BUS_IDLE;
			end
		end else if (newJob.valid) begin
			next_slot = newJob;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state  <= prefetch_pkg::BUS_IDLE;
			active <= '0;
			slot   <= '0;
			acc    <= '0;
		end else begin
			state  <= next_state;
			active <= next_active;
			slot   <= next_slot;
			acc    <= next_acc;
		end
	end

	// Prefetch delivery, line capture and cache fill
	always_comb begin
		next_fetchBusy     = fetchBusy;
		next_fetchOdd      = fetchOdd;
		next_lineValid     = lineValid;
		next_lineAddr      = lineAddr;
		next_lineData      = lineData;
		next_fetchValid    = 1'b0;
		next_fetchWord     = fetchWord;
		next_cacheFill     = 1'b0;
		next_cacheFillAddr = cacheFillAddr;
		next_cacheFillData = cacheFillData;
		if (fetchTake && cacheHit) begin
			next_fetchValid = 1'b1;
			next_fetchWord  = cacheWord;
		end else if (fetchTake && lineHit) begin
			next_fetchValid = 1'b1;
			next_fetchWord  = lineWord;
		end else if (fetchTake) begin
			next_fetchBusy = 1'b1;
			next_fetchOdd  = fetchAddr[1];
			next_lineAddr  = fetchAddr & `LONG_MASK;
			next_lineValid = 1'b0;
		end
		if (lastChunk && active.fetch) begin
			next_fetchBusy     = 1'b0;
			next_fetchValid    = 1'b1;
			next_fetchWord     = fetchOdd ? readValue[15:0] : readValue[31:16];
			next_lineValid     = 1'b1;
			next_lineData      = readValue;
			next_cacheFill     = 1'b1;
			next_cacheFillAddr = lineAddr;
			next_cacheFillData = readValue;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			fetchBusy     <= 1'b0;
			fetchOdd      <= 1'b0;
			lineValid     <= 1'b0;
			lineAddr      <= '0;
			lineData      <= '0;
			fetchValid    <= 1'b0;
			fetchWord     <= '0;
			cacheFill     <= 1'b0;
			cacheFillAddr <= '0;
			cacheFillData <= '0;
		end else begin
			fetchBusy     <= next_fetchBusy;
			fetchOdd      <= next_fetchOdd;
			lineValid     <= next_lineValid;
			lineAddr      <= next_lineAddr;
			lineData      <= next_lineData;
			fetchValid    <= next_fetchValid;
			fetchWord     <= next_fetchWord;
			cacheFill     <= next_cacheFill;
			cacheFillAddr <= next_cacheFillAddr;
			cacheFillData <= next_cacheFillData;
		end
	end

	// Operand completion; writes are posted at acceptance
	always_comb begin
		next_readBusy = readBusy;
		next_opDone   = 1'b0;
		next_opRData  = opRData;
		if (opAccept && opIn.write) begin
			next_opDone = 1'b1;
		end else if (opAccept) begin
			next_readBusy = 1'b1;
		end
		if (lastChunk && !active.fetch && !active.write) begin
			next_readBusy = 1'b0;
			next_opDone   = 1'b1;
			next_opRData  = readValue;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			readBusy <= 1'b0;
			opDone   <= 1'b0;
			opRData  <= '0;
		end else begin
			readBusy <= next_readBusy;
			opDone   <= next_opDone;
			opRData  <= next_opRData;
		end
	end

	// Serialisation on outstanding writes
	assign writesPending = (active.valid && active.write) || (slot.valid && slot.write);
	assign nopDone       = nopReq && !writesPending;

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_hit_no_bus: assert property (fetchTake && cacheHit |=> fetchValid && !fetchBusy
		&& fetchWord == $past(cacheWord)) else $error("Cache hit not delivered");
	a_fill_fetch_only: assert property (lastChunk && !active.fetch |=> !cacheFill)
		else $error("Operand data filled cache");
	a_miss_reads: assert property (fetchTake && fetchMiss |=> fetchBusy
		&& (active.fetch || slot.fetch)) else $error("Miss started no read");
	a_fetch_long: assert property (newJob.valid && newJob.fetch |-> newJob.bytes == `BYTES_LONG
		&& newJob.addr[1:0] == 2'b00) else $error("Fetch not long-word");
	a_line_reuse: assert property (fetchTake && lineHit && !cacheHit |=> fetchValid
		&& fetchWord == $past(lineWord) && !fetchBusy) else $error("Line word not reused");
	a_split_cycle: assert property (running && memAck && chunk != active.bytes |=> running
		&& active.bytes == $past(active.bytes) - $past(chunk)) else $error("Bad split");
	a_queue_start: assert property (lastChunk && slot.valid |=> running
		&& active == $past(slot) && !slot.valid) else $error("Queued job not started");
	a_write_posted: assert property (opAccept && opIn.write |=> opDone)
		else $error("Write not posted");
	a_nop_wait: assert property (nopReq && writesPending |-> !nopDone)
		else $error("Serialise passed pending write");
	a_slot_stall: assert property (slot.valid |-> !opReady && !(fetchReady && fetchMiss))
		else $error("Request accepted with full queue");

	c_queued: cover property (lastChunk && slot.valid);
	c_line_hit: cover property (fetchTake && lineHit && !cacheHit);
	c_nop_wait: cover property (nopReq && !nopDone ##1 nopReq && nopDone);
	c_split: cover property (running && memAck && chunk != active.bytes);

endmodule

// ===== src/prefetch_map.svh
`ifndef PREFETCH_MAP_SVH
`define PREFETCH_MAP_SVH

// Long-word base of an address
`define LONG_MASK 32'hFFFF_FFFC
// Transfer sizes in bytes
`define BYTES_WORD 3'h2
`define BYTES_LONG 3'h4
`define BYTES_BYTE 3'h1
// Memory port width codes
`define PORT_8 2'h0
`define PORT_16 2'h1
`define PORT_32 2'h2

`endif

// ===== src/prefetch_pkg.sv
package prefetch_pkg;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_RUN  = 2'b10
	} bus_state_e;

	// One bus controller job: data left-justified for writes
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        fetch;
		logic [31:0] addr;
		logic [2:0]  bytes;
		logic [31:0] data;
	} job_s;

	// Request to external memory for one bus cycle
	typedef struct packed {
		logic        request;
		logic        write;
		logic [31:0] addr;
		logic [2:0]  size;
		logic [31:0] wdata;
	} mem_req_s;

	// Operand request from the sequencer
	typedef struct packed {
		logic        request;
		logic        write;
		logic        isLong;
		logic [31:0] addr;
		logic [31:0] wdata;
	} op_req_s;

endpackage

// ===== bench/mem_model.sv
module mem_model (
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   reset,
	// Bus side
	input  wire prefetch_pkg::mem_req_s memOut,
	input  wire logic [3:0]             waitCyc,
	output logic                        memAck,
	output logic [31:0]                 memRData
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [67:0] busLog[$];
	logic [3:0]  cnt = 4'h0;
	function automatic logic [31:0] rd(input logic [31:0] a, input logic [2:0] n);
		logic [31:0] x;
		rd = 32'h0000_0000;
		for (int i = 0; i < n; i++) begin
			x = a + i;
			rd = {rd[23:0], x[7:0] ^ x[15:8] ^ 8'h3C};
		end
	endfunction
	initial memRData = 32'h5A5A_A5A5;
	// Idle bus inverts every cycle, showing the last data again every other cycle
	always @(posedge clock) begin
		memRData <= ~memRData;
		if (reset || memAck) begin
			memAck <= 1'b0;
			cnt <= 4'h0;
		end else if (memOut.request) begin
			if (cnt == waitCyc) begin
				memAck <= 1'b1;
				if (!memOut.write)
					memRData <= rd(memOut.addr, memOut.size);
				busLog.push_back({memOut.write, memOut.addr, memOut.size, memOut.write ?
					memOut.wdata & 32'((64'h1 << (8 * memOut.size)) - 1) :
					rd(memOut.addr, memOut.size)});
			end else
				cnt <= cnt + 4'h1;
		end
	end
endmodule

// ===== bench/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic                   clock = 0, reset = 1, fetchReq = 0, cacheHit = 0, nopReq = 0;
	logic [31:0]            fetchAddr = 0, cacheFillAddr, cacheFillData, opRData, memRData;
	logic [31:0]            fillD, fillA, b, d;
	logic [15:0]            cacheWord = 0, fetchWord;
	logic [1:0]             portWidth = 0;
	logic [3:0]             waitCyc = 0;
	logic                   fetchReady, fetchValid, cacheFill, opReady, opDone;
	logic                   nopDone, writesPending, memAck;
	prefetch_pkg::op_req_s  opIn = '0;
	prefetch_pkg::mem_req_s memOut;
	logic [67:0]            expLog[$];
	int                     errTotal = 0, checked = 0, fills = 0, cycles = 0;
	always #20 clock = ~clock;
	prefetch_bus_sequencer_overlap prefetch_bus_sequencer_overlap_inst (.clock, .reset,
		.fetchReq, .fetchAddr, .fetchReady, .fetchValid, .fetchWord, .cacheHit, .cacheWord,
		.cacheFill, .cacheFillAddr, .cacheFillData, .opIn, .opReady, .opDone, .opRData,
		.nopReq, .nopDone, .writesPending, .portWidth, .memOut, .memAck, .memRData);
	mem_model mem_model_inst (.clock, .reset, .memOut, .waitCyc, .memAck, .memRData);
	function automatic logic [31:0] rd(input logic [31:0] a, input logic [2:0] n);
		logic [31:0] x;
		rd = 32'h0000_0000;
		for (int i = 0; i < n; i++) begin
			x = a + i;
			rd = {rd[23:0], x[7:0] ^ x[15:8] ^ 8'h3C};
		end
	endfunction
	function automatic logic [31:0] msk(input logic [2:0] n);
		return 32'((64'h1 << (8 * n)) - 1);
	endfunction
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checked, errTotal);
		if (errTotal == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [67:0] seen, input logic [67:0] exp);
		checked++;
		if (seen !== exp) begin
			errTotal++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cacheFill) begin
			fills++;
			fillD = cacheFillData;
			fillA = cacheFillAddr;
			check(cacheFillAddr & 32'h0000_0003, 0);
		end
		if (cycles == 30000) begin
			errTotal++;
			report_and_stop();
		end
	end
	// Splits one transfer into port-sized chunks, most significant first
	task automatic expect_bus(input logic w, input logic [31:0] a, input logic [2:0] n,
		input logic [31:0] d);
		logic [2:0] c, p;
		p = portWidth == 0 ? 3'h1 : portWidth == 1 ? 3'h2 : 3'h4;
		while (n > 0) begin
			c = p - (a[2:0] & (p - 3'h1));
			if (c > n)
				c = n;
			n = n - c;
			expLog.push_back({w, a, c, w ? (d >> (8 * n)) & msk(c) : rd(a, c)});
			a = a + 32'(c);
		end
	endtask
	task automatic cmp_log();
		for (int i = 0; i < 300 && (memOut.request || writesPending); i++)
			@(negedge clock);
		check(mem_model_inst.busLog.size(), expLog.size());
		while (expLog.size() > 0 && mem_model_inst.busLog.size() > 0)
			check(mem_model_inst.busLog.pop_front(), expLog.pop_front());
		expLog.delete();
		mem_model_inst.busLog.delete();
	endtask
	task automatic fetch(input logic [31:0] a, input logic hit, input logic miss);
		logic [15:0] w;
		int f0;
		@(negedge clock);
		w = 16'($urandom);
		f0 = fills;
		if (miss)
			expect_bus(0, a & 32'hFFFF_FFFC, 4, 0);
		fetchReq = 1;
		fetchAddr = a;
		cacheHit = hit;
		cacheWord = w;
		#1;
		for (int i = 0; i < 300 && !fetchReady; i++)
			@(negedge clock);
		@(negedge clock);
		fetchReq = 0;
		if (!miss)
			check(fetchValid, 1);
		for (int i = 0; i < 300 && fetchValid !== 1; i++)
			@(negedge clock);
		// Fill pulse is counted at the next rising edge
		@(negedge clock);
		check(fetchWord, hit ? w : rd(a, 2));
		cmp_log();
		check(fills, f0 + miss);
		if (miss)
			check(fillD, rd(a & 32'hFFFF_FFFC, 4));
		if (miss)
			check(fillA, a & 32'hFFFF_FFFC);
	endtask
	task automatic op(input logic w, input logic l, input logic [31:0] a, input logic [31:0] d);
		int f0;
		@(negedge clock);
		f0 = fills;
		expect_bus(w, a, l ? 3'h4 : 3'h2, d);
		opIn = {1'b1, w, l, a, d};
		#1;
		for (int i = 0; i < 300 && !opReady; i++)
			@(negedge clock);
		@(negedge clock);
		opIn.request = 0;
		if (w)
			check(opDone, 1);
		for (int i = 0; i < 300 && opDone !== 1; i++)
			@(negedge clock);
		if (!w)
			check(opRData, rd(a, l ? 3'h4 : 3'h2));
		cmp_log();
		check(fills, f0);
	endtask
	initial begin
		void'($urandom(32'h4976064f));
		repeat (10) @(negedge clock);
		reset = 0;
		for (int p = 0; p < 3; p++) begin
			portWidth = 2'(p);
			waitCyc = 4'($urandom % 3);
			b = $urandom & 32'h00FF_FFC0;
			fetch(b, 0, 1);
			fetch(b + 2, 0, 0);
			fetch(b + 22, 0, 1);
			fetch(b + 40, 1, 0);
			op(1, 1, b + 3, $urandom);
			op(0, 0, b + 7, 0);
			repeat (8) op(1'($urandom), 1'($urandom), $urandom & 32'h00FF_FFFF, $urandom);
		end
		@(negedge clock);
		portWidth = 2;
		waitCyc = 3;
		nopReq = 1;
		d = $urandom;
		expect_bus(1, b, 4, d);
		expect_bus(1, b, 4, d);
		opIn = {1'b1, 1'b1, 1'b1, b, d};
		@(negedge clock);
		check(opReady, 1);
		@(negedge clock);
		check(opReady, 0);
		check(nopDone, 0);
		opIn.request = 0;
		fetchReq = 1;
		fetchAddr = b + 64;
		cacheHit = 1;
		@(negedge clock);
		fetchReq = 0;
		check(fetchValid, 1);
		check(writesPending, 1);
		for (int i = 0; i < 100 && !nopDone; i++)
			@(negedge clock);
		check(nopDone, 1);
		cmp_log();
		report_and_stop();
	end
endmodule
